// ---- rtl/chs_pkg.sv ----
// Constants, states and carriers for the charger SMBus slave engine.
// Assumes the host-side timing figures and the 12 ns link clock of the bench.
package chs_pkg;

    // Bus addresses and command codes
    localparam logic [7:0] WR_ADDR = 8'h12;
    localparam logic [7:0] RD_ADDR = 8'h13;
    localparam logic [7:0] CMD_MODE = 8'h12;
    localparam logic [7:0] CMD_STATUS = 8'h13;
    localparam logic [7:0] CMD_CCUR = 8'h14;
    localparam logic [7:0] CMD_CVOLT = 8'h15;
    localparam logic [7:0] CMD_ICUR = 8'h3F;

    // Longest SCL high time before a repeated start, then link cycles
    localparam int T_HIGH_MAX_NS = 50000;
    localparam int LINK_PERIOD_NS = 12;
    localparam int HIGH_MAX_CYC = T_HIGH_MAX_NS / LINK_PERIOD_NS;

    // Status word layout
    localparam int STAT_AC_OC_BIT = 1;
    localparam int STAT_CHG_OC_BIT = 2;

    // Values after reset, bits per byte and the SCL high counter limit
    localparam logic [15:0] RST_MODE = 16'h0000;
    localparam logic [15:0] RST_CCUR = 16'h0000;
    localparam logic [15:0] RST_CVOLT = 16'h0000;
    localparam logic [15:0] RST_ICUR = 16'h0000;
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [15:0] HICNT_SAT = 16'hFFFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK_SETUP = 3'b010,
        ST_ACK_HOLD = 3'b011,
        ST_TX = 3'b100,
        ST_TX_ACK = 3'b101,
        ST_IGNORE = 3'b110
    } chs_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_D0 = 2'b10,
        PH_D1 = 2'b11
    } chs_phase_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] ccur;
        logic [15:0] cvolt;
        logic [15:0] icur;
    } chs_ctrl_t;

endpackage

// ---- rtl/chs_sync.sv ----
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level or a toggle that changes slowly against clk.
`timescale 1ns/10ps
module chs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } chs_sync_state_t;

    chs_sync_state_t s_reg;
    chs_sync_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.stage1 = d;
        s_next.stage2 = s_reg.stage1;
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign q = s_reg.stage2;
endmodule

// ---- rtl/chs_smbus_slave.sv ----
// SMBus word-read/word-write slave of the charger with status latches and alert.
// Assumes SCL/SDA pins settle externally; link_clk samples them, clk runs the status side.
`timescale 1ns/10ps

// Behaviour
// R1: Read address acked only after repeated start with SCL high under 50 us.
// R2: After read address ack, two bytes of the selected register are sent.
// R3: START or STOP overrides any transfer step in progress.
// R4: Host issues STOP when lost; engine then returns to idle.
// R5: Idle engine ignores SCL and SDA until a START.
// R6: Host restarts an interrupted read from the beginning for valid data.
// R7: Any address other than own write or read address is not acked.
// R8: Reserved or unsupported command byte is not acked.
// R9: A valid command selects the register for both write and read; code refuses data after status (0x13).
// R10: Any status bit change raises the alert output.
// R11: Charger overcurrent latches its status bit until a host status read.
// R12: Adapter overcurrent latches its status bit until a host status read.
// R13: Own addresses are 0x12 for write and 0x13 for read.
// R14: Valid commands are 0x12, 0x13, 0x14, 0x15 and 0x3F.
// R15: Word write commits only at end of second data ack.
// R16: Host acks first read byte, nacks second, then sends STOP.
// R17: Released overcurrent bit follows live detection and re-latches.
module chs_smbus_slave #(
    parameter int HIGH_MAX_CYC = chs_pkg::HIGH_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [15:0] live_status,
    input wire logic chg_oc_detect,
    input wire logic ac_oc_detect,
    output logic alert,
    output chs_pkg::chs_ctrl_t ctrl
);
    import chs_pkg::*;

    typedef struct packed {
        logic chg_flag;
        logic ac_flag;
        logic [15:0] status_word;
        logic alert;
        logic [15:0] pub;
        logic req_tgl;
        logic rel_seen;
    } chs_sys_t;

    typedef struct packed {
        chs_state_t st;
        chs_phase_t ph;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] txhi;
        logic [7:0] cmd;
        logic cmd_ready;
        logic rd_allowed;
        logic go_tx;
        logic commit;
        logic byte_idx;
        logic host_ack;
        logic [7:0] wlo;
        chs_ctrl_t regs;
        logic sda_oe;
        logic sda_o;
        logic scl_d;
        logic sda_d;
        logic [15:0] hicnt;
        logic [15:0] snap;
        logic ack_tgl;
        logic rel_tgl;
    } chs_link_t;

    function automatic logic is_valid_cmd(input logic [7:0] c);
        is_valid_cmd = (c == CMD_MODE) || (c == CMD_STATUS) || (c == CMD_CCUR)
            || (c == CMD_CVOLT) || (c == CMD_ICUR);
    endfunction

    chs_sys_t s_reg;
    chs_sys_t s_next;
    chs_link_t l_reg;
    chs_link_t l_next;

    logic [1:0] sys_in;
    logic [3:0] link_in;
    logic link_rst;
    logic req_s;
    logic scl_s;
    logic sda_s;
    logic ack_s;
    logic rel_s;

    // Pins, request toggle and reset into the link domain
    chs_sync #(.WIDTH(4)) u_link_sync (
        .clk(link_clk),
        .d({rst, s_reg.req_tgl, scl_i, sda_i}),
        .q(link_in)
    );

    // Acknowledge and release toggles into the system domain
    chs_sync #(.WIDTH(2)) u_sys_sync (
        .clk(clk),
        .d({l_reg.ack_tgl, l_reg.rel_tgl}),
        .q(sys_in)
    );

    assign link_rst = link_in[3];
    assign req_s = link_in[2];
    assign scl_s = link_in[1];
    assign sda_s = link_in[0];
    assign ack_s = sys_in[1];
    assign rel_s = sys_in[0];

    // System domain: overcurrent latches, status word, alert, publishing
    always_comb begin
        logic release_evt;
        logic [15:0] word;
        release_evt = 1'b0;
        word = '0;
        s_next = s_reg;
        release_evt = (rel_s != s_reg.rel_seen);
        s_next.rel_seen = rel_s;
        // Detection wins over a release in the same cycle
        s_next.chg_flag = chg_oc_detect | (s_reg.chg_flag & ~release_evt); // R11 R17
        s_next.ac_flag = ac_oc_detect | (s_reg.ac_flag & ~release_evt); // R12 R17
        word = live_status;
        word[STAT_CHG_OC_BIT] = s_next.chg_flag; // R11
        word[STAT_AC_OC_BIT] = s_next.ac_flag; // R12
        s_next.status_word = word;
        s_next.alert = (word != s_reg.status_word) | (s_reg.alert & ~release_evt); // R10
        // New snapshot only once the link side has taken the previous one
        if ((ack_s == s_reg.req_tgl) && (s_reg.pub != s_reg.status_word)) begin
            s_next.pub = s_reg.status_word;
            s_next.req_tgl = ~s_reg.req_tgl;
        end
        if (rst) begin
            s_next = '0;
            s_next.status_word = RST_STATUS;
            s_next.pub = RST_STATUS;
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    // Link domain: SMBus protocol engine
    always_comb begin
        logic rise;
        logic fall;
        logic start_evt;
        logic stop_evt;
        logic [15:0] rd_word;
        rise = 1'b0;
        fall = 1'b0;
        start_evt = 1'b0;
        stop_evt = 1'b0;
        rd_word = '0;
        l_next = l_reg;
        rise = scl_s & ~l_reg.scl_d;
        fall = ~scl_s & l_reg.scl_d;
        start_evt = scl_s & l_reg.scl_d & l_reg.sda_d & ~sda_s;
        stop_evt = scl_s & l_reg.scl_d & ~l_reg.sda_d & sda_s;
        l_next.scl_d = scl_s;
        l_next.sda_d = sda_s;

        if (!scl_s) begin
            l_next.hicnt = '0;
        end else if (l_reg.hicnt != HICNT_SAT) begin
            l_next.hicnt = l_reg.hicnt + 16'h0001;
        end

        if (req_s != l_reg.ack_tgl) begin
            l_next.snap = s_reg.pub;
            l_next.ack_tgl = req_s;
        end

        case (l_reg.cmd)
            CMD_MODE: rd_word = l_reg.regs.mode;
            CMD_STATUS: rd_word = l_reg.snap;
            CMD_CCUR: rd_word = l_reg.regs.ccur;
            CMD_CVOLT: rd_word = l_reg.regs.cvolt;
            CMD_ICUR: rd_word = l_reg.regs.icur;
            default: rd_word = '0;
        endcase

        case (l_reg.st)
            ST_IDLE: begin
                l_next.sda_oe = 1'b0; // R5
            end
            ST_RX: begin
                if (rise) begin
                    l_next.shreg = {l_reg.shreg[6:0], sda_s};
                    l_next.bitcnt = l_reg.bitcnt + 4'h1;
                    if (l_reg.bitcnt == BITS_PER_BYTE - 4'h1) begin
                        l_next.st = ST_ACK_SETUP;
                    end
                end
            end
            ST_ACK_SETUP: begin
                if (fall) begin
                    l_next.st = ST_IGNORE;
                    l_next.go_tx = 1'b0;
                    l_next.commit = 1'b0;
                    case (l_reg.ph)
                        PH_ADDR: begin
                            if (l_reg.shreg == WR_ADDR) begin // R13
                                l_next.st = ST_ACK_HOLD;
                                l_next.ph = PH_CMD;
                            end else if ((l_reg.shreg == RD_ADDR) && l_reg.rd_allowed) begin // R1
                                l_next.st = ST_ACK_HOLD;
                                l_next.go_tx = 1'b1;
                            end
                        end
                        PH_CMD: begin
                            if (is_valid_cmd(l_reg.shreg)) begin // R8 R14
                                l_next.st = ST_ACK_HOLD;
                                l_next.cmd = l_reg.shreg; // R9
                                l_next.cmd_ready = 1'b1;
                                l_next.ph = PH_D0;
                            end
                        end
                        PH_D0: begin
                            if (l_reg.cmd != CMD_STATUS) begin
                                l_next.st = ST_ACK_HOLD;
                                l_next.wlo = l_reg.shreg;
                                l_next.ph = PH_D1;
                            end
                        end
                        PH_D1: begin
                            l_next.st = ST_ACK_HOLD;
                            l_next.commit = 1'b1;
                        end
                        default: l_next.st = ST_IGNORE;
                    endcase
                    l_next.sda_oe = (l_next.st == ST_ACK_HOLD); // R7
                end
            end
            ST_ACK_HOLD: begin
                if (fall) begin
                    l_next.sda_oe = 1'b0;
                    l_next.bitcnt = '0;
                    l_next.st = ST_RX;
                    if (l_reg.commit) begin // R15
                        l_next.commit = 1'b0;
                        l_next.st = ST_IGNORE;
                        case (l_reg.cmd)
                            CMD_MODE: l_next.regs.mode = {l_reg.shreg, l_reg.wlo};
                            CMD_CCUR: l_next.regs.ccur = {l_reg.shreg, l_reg.wlo};
                            CMD_CVOLT: l_next.regs.cvolt = {l_reg.shreg, l_reg.wlo};
                            CMD_ICUR: l_next.regs.icur = {l_reg.shreg, l_reg.wlo};
                            default: l_next.regs = l_reg.regs;
                        endcase
                    end else if (l_reg.go_tx) begin // R2
                        l_next.go_tx = 1'b0;
                        l_next.shreg = rd_word[7:0];
                        l_next.txhi = rd_word[15:8];
                        l_next.byte_idx = 1'b0;
                        l_next.sda_oe = ~rd_word[7];
                        l_next.st = ST_TX;
                    end
                end
            end
            ST_TX: begin
                if (rise) begin
                    l_next.bitcnt = l_reg.bitcnt + 4'h1;
                end
                if (fall) begin
                    if (l_reg.bitcnt == BITS_PER_BYTE) begin
                        l_next.sda_oe = 1'b0;
                        l_next.st = ST_TX_ACK;
                    end else begin
                        l_next.shreg = {l_reg.shreg[6:0], 1'b0};
                        l_next.sda_oe = ~l_reg.shreg[6];
                    end
                end
            end
            ST_TX_ACK: begin
                if (rise) begin
                    l_next.host_ack = ~sda_s;
                end
                if (fall) begin
                    l_next.st = ST_IGNORE;
                    if (l_reg.host_ack && !l_reg.byte_idx) begin // R2 R16
                        l_next.byte_idx = 1'b1;
                        l_next.shreg = l_reg.txhi;
                        l_next.sda_oe = ~l_reg.txhi[7];
                        l_next.bitcnt = '0;
                        l_next.st = ST_TX;
                        if (l_reg.cmd == CMD_STATUS) begin
                            l_next.rel_tgl = ~l_reg.rel_tgl; // R11 R12
                        end
                    end
                end
            end
            ST_IGNORE: begin
                l_next.sda_oe = 1'b0;
            end
            default: begin
                l_next.st = ST_IDLE;
                l_next.sda_oe = 1'b0;
            end
        endcase

        // Bus conditions take priority over any step above
        if (start_evt) begin // R3
            l_next.st = ST_RX;
            l_next.ph = PH_ADDR;
            l_next.bitcnt = '0;
            l_next.sda_oe = 1'b0;
            l_next.go_tx = 1'b0;
            l_next.commit = 1'b0;
            l_next.rd_allowed = l_reg.cmd_ready && (l_reg.hicnt < HIGH_MAX_CYC[15:0]); // R1
            l_next.cmd_ready = 1'b0;
        end else if (stop_evt) begin // R3 R4
            l_next.st = ST_IDLE;
            l_next.sda_oe = 1'b0;
            l_next.go_tx = 1'b0;
            l_next.commit = 1'b0;
            l_next.cmd_ready = 1'b0;
            l_next.rd_allowed = 1'b0;
        end

        if (link_rst) begin
            l_next = '0;
            l_next.st = ST_IDLE;
            l_next.ph = PH_ADDR;
            l_next.regs.mode = RST_MODE;
            l_next.regs.ccur = RST_CCUR;
            l_next.regs.cvolt = RST_CVOLT;
            l_next.regs.icur = RST_ICUR;
            l_next.snap = RST_STATUS;
        end
    end

    always_ff @(posedge link_clk) begin
        l_reg <= l_next;
    end

    assign sda_o = l_reg.sda_o;
    assign sda_oe = l_reg.sda_oe;
    assign ctrl = l_reg.regs;
    assign alert = s_reg.alert;
endmodule

// ---- test/chs_chk.sv ----
// Port assertions for the charger SMBus slave.
// Assumes SCL phases last many link cycles, as the bench host makes them.
`timescale 1ns/10ps
module chs_chk #(
    parameter int HIGH_MAX_CYC = 50
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [15:0] live_status,
    input wire logic chg_oc_detect,
    input wire logic ac_oc_detect,
    input wire logic alert,
    input wire chs_pkg::chs_ctrl_t ctrl
);
    import chs_pkg::*;
    a_oe_scl_low: assert property (@(posedge link_clk) disable iff (rst)
        $rose(sda_oe) || $fell(sda_oe) |-> !scl_i) else $error("sda_oe moved with SCL high");
    a_sda_drive_low: assert property (@(posedge link_clk) disable iff (rst)
        sda_oe |-> !sda_o) else $error("sda driven high while enabled");
    a_oe_sync_lag: assert property (@(posedge link_clk) disable iff (rst)
        $fell(scl_i) |=> $stable(sda_oe)) else $error("sda_oe moved too soon after SCL fall");
    a_start_release: assert property (@(posedge link_clk) disable iff (rst)
        scl_i && $fell(sda_i) |-> ##4 !sda_oe [*4]) else $error("sda_oe driven after START");
    a_stop_idle: assert property (@(posedge link_clk) disable iff (rst)
        scl_i && $rose(sda_i) |-> ##4 !sda_oe [*8]) else $error("sda_oe driven after STOP");
    a_ctrl_scl_low: assert property (@(posedge link_clk) disable iff (rst)
        !$stable(ctrl) |-> !scl_i) else $error("control word changed with SCL high");
    a_alert_change: assert property (@(posedge clk) disable iff (rst)
        (live_status & 16'hFFF9) != ($past(live_status) & 16'hFFF9) |-> ##[1:3] alert)
        else $error("no alert after status change");
    a_chg_oc_alert: assert property (@(posedge clk) disable iff (rst)
        $rose(chg_oc_detect) && !alert |-> ##[1:3] alert) else $error("no alert on charger oc");
    a_ac_oc_alert: assert property (@(posedge clk) disable iff (rst)
        $rose(ac_oc_detect) && !alert |-> ##[1:3] alert) else $error("no alert on adapter oc");
endmodule
bind chs_smbus_slave chs_chk #(.HIGH_MAX_CYC(HIGH_MAX_CYC)) i_chs_chk (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .live_status(live_status),
    .chg_oc_detect(chg_oc_detect), .ac_oc_detect(ac_oc_detect), .alert(alert), .ctrl(ctrl));

// ---- test/chs_host.sv ----
// Host controller model: drives SCL and pulls SDA low, bit by bit.
// Assumes the bench resolves SDA with a pull-up; SCL idles high between frames.
`timescale 1ns/10ps
module chs_host (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    import chs_pkg::*;
    localparam int Q = 250;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Data set with SCL low, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_pull = !b;
        #Q;
        scl = 1'b1;
        #Q;
        s = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    // START or repeated start; hi_ns sets the SCL high time before it
    task automatic start(input int hi_ns);
        sda_pull = 1'b0;
        #Q;
        scl = 1'b1;
        #(hi_ns);
        sda_pull = 1'b1;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_pull = 1'b0;
        #Q;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(!ack, s);
    endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the charger SMBus slave with a host model.
// Assumes SDA has a pull-up; the link clock runs free beside clk.
`timescale 1ns/10ps
module testbench;
    import chs_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic host_pull;
    logic sda_oe;
    logic sda_o;
    logic alert;
    logic [15:0] live_status = 16'h0000;
    logic chg_oc = 1'b0;
    logic ac_oc = 1'b0;
    logic [3:0] acks;
    chs_ctrl_t ctrl;
    wire sda = host_pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    int errors = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    initial begin
        #4;
        forever #6 link_clk = ~link_clk;
    end
    chs_smbus_slave #(.HIGH_MAX_CYC(50)) i_chs_smbus_slave (
        .clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .live_status(live_status), .chg_oc_detect(chg_oc),
        .ac_oc_detect(ac_oc), .alert(alert), .ctrl(ctrl));
    chs_host i_chs_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic head(input logic [7:0] addr, input logic [7:0] cmd);
        i_chs_host.start(250);
        i_chs_host.wbyte(addr, acks[0]);
        i_chs_host.wbyte(cmd, acks[1]);
    endtask
    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] w);
        head(WR_ADDR, cmd);
        i_chs_host.wbyte(w[7:0], acks[2]);
        i_chs_host.wbyte(w[15:8], acks[3]);
        i_chs_host.stop();
    endtask
    task automatic rd_word(input logic [7:0] cmd, input int hi_ns, output logic [15:0] w);
        head(WR_ADDR, cmd);
        i_chs_host.start(hi_ns);
        i_chs_host.wbyte(RD_ADDR, acks[2]);
        i_chs_host.rbyte(1'b1, w[7:0]);
        i_chs_host.rbyte(1'b0, w[15:8]);
        i_chs_host.stop();
    endtask
    task automatic s_write_read();
        logic [15:0] w;
        logic [7:0] cmds [4];
        cmds = '{CMD_MODE, CMD_CCUR, CMD_CVOLT, CMD_ICUR};
        for (int i = 0; i < 4; i++) begin
            wr_word(cmds[i], 16'hA150 + 16'(i));
            check("write acks", {12'h0, acks}, 16'h000F);
            rd_word(cmds[i], 250, w);
            check("read acks", {13'h0, acks[2:0]}, 16'h0007);
            check("read word", w, 16'hA150 + 16'(i));
        end
        check("mode", ctrl.mode, 16'hA150);
        check("ccur", ctrl.ccur, 16'hA151);
        check("cvolt", ctrl.cvolt, 16'hA152);
        check("icur", ctrl.icur, 16'hA153);
    endtask
    task automatic s_refusals();
        logic [15:0] w;
        head(8'h24, CMD_MODE);
        i_chs_host.stop();
        check("foreign address", {14'h0, acks[1:0]}, 16'h0000);
        head(RD_ADDR, CMD_MODE);
        i_chs_host.stop();
        check("bare read address", {15'h0, acks[0]}, 16'h0000);
        rd_word(8'h16, 250, w);
        check("reserved command", {13'h0, acks[2:0]}, 16'h0001);
        head(WR_ADDR, CMD_CCUR);
        i_chs_host.wbyte(8'h77, acks[2]);
        i_chs_host.stop();
        check("aborted write", ctrl.ccur, 16'hA151);
        head(WR_ADDR, CMD_STATUS);
        i_chs_host.wbyte(8'h55, acks[2]);
        i_chs_host.stop();
        check("status write", {14'h0, acks[2:1]}, 16'h0001);
        rd_word(CMD_CVOLT, 1000, w);
        check("slow restart", {15'h0, acks[2]}, 16'h0000);
        rd_word(CMD_CVOLT, 250, w); // Whole read repeated
        check("repeated read", w, 16'hA152);
    endtask
    task automatic s_status();
        logic [15:0] w;
        logic [15:0] oc;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #2;
            // Later rounds keep live bits, so the alert comes from a latch alone
            if (k < 2) begin
                live_status = 16'h0100 << k;
            end
            {chg_oc, ac_oc} = k[0] ? 2'b01 : 2'b10;
            oc = k[0] ? 16'h0002 : 16'h0004;
            repeat (3) @(posedge clk);
            #2;
            {chg_oc, ac_oc} = 2'b00;
            for (int n = 0; n < 20 && alert !== 1'b1; n++) @(posedge clk);
            check("alert", {15'h0, alert}, 16'h0001);
            if (alert !== 1'b1) tally_and_finish();
            repeat (60) @(posedge clk);
            #2;
            rd_word(CMD_STATUS, 250, w);
            check("status latched", w, live_status | oc);
            repeat (60) @(posedge clk);
            #2;
            rd_word(CMD_STATUS, 250, w);
            check("status released", w, live_status);
            check("alert cleared", {15'h0, alert}, 16'h0000);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #2;
        check("ctrl reset", ctrl.mode | ctrl.ccur | ctrl.cvolt | ctrl.icur, 16'h0000);
        check("idle sda", {15'h0, sda_oe}, 16'h0000);
        s_write_read();
        s_refusals();
        s_status();
        tally_and_finish();
    end
endmodule
